/* File: mdmd_pkg.sv */
// Shared constants and types for the MDIO manageable device block
package mdmd_pkg;
  // Register byte addresses
  localparam logic [31:0] ADDR_CONTROL = 32'h40005c00;
  localparam logic [31:0] ADDR_FRAME_INFO = 32'h40005c04;
  localparam logic [31:0] ADDR_WRITE_DATA = 32'h40005c08;
  localparam logic [31:0] ADDR_ADDRESS = 32'h40005c0c;
  localparam logic [31:0] ADDR_REPLY = 32'h40005c10;
  localparam logic [31:0] ADDR_EXPECTED = 32'h40005c14;
  localparam logic [31:0] ADDR_PROGRESS = 32'h40005c18;
  localparam logic [31:0] ADDR_IRQ_EN = 32'h40005c1c;
  localparam logic [31:0] ADDR_PIN_LEVELS = 32'h40005c20;
  // Reset values
  localparam logic [15:0] EXPECTED_CFG_RST = 16'h0400;
  localparam logic [15:0] REG_ZERO_RST = 16'h0000;
  // Field positions and widths
  localparam int DEVADD_LSB = 10;
  localparam int PORTSEL_LSB = 5;
  localparam int PORTSW_LSB = 0;
  localparam int FIELD_W = 5;
  localparam int PORT_WIDTH_SELECT_BIT = 1;
  localparam int NARROW_BITS = 3;
  // Progress flag positions
  localparam int PORT_MISMATCH_FLAG = 7;
  localparam int PORT_MATCH_FLAG = 6;
  localparam int DEVICE_MISMATCH_FLAG = 5;
  localparam int DEVICE_MATCH_FLAG = 4;
  localparam int READ_FRAME_DONE = 3;
  localparam int INCREMENT_FRAME_DONE = 2;
  localparam int ADDRESS_FRAME_DONE = 1;
  localparam int WRITE_FRAME_DONE = 0;
  // Opcodes
  localparam logic [1:0] OP_SET_ADDRESS = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h3;
  localparam logic [1:0] OP_READ_INC = 2'h2;
  // Frame bit counts
  localparam logic [5:0] PREAMBLE_MIN = 6'h20;
  localparam logic [3:0] OP_LAST = 4'h1;
  localparam logic [3:0] FIELD_LAST = 4'h4;
  localparam logic [3:0] TA_LAST = 4'h1;
  localparam logic [3:0] DATA_LAST = 4'hf;
  typedef enum logic [2:0] {
    S_PRE = 3'b000, S_ST = 3'b001, S_OP = 3'b010, S_PRT = 3'b011,
    S_DEV = 3'b100, S_TA = 3'b101, S_DATA = 3'b110
  } mdmd_state_t;
  typedef enum logic [3:0] {
    R_NONE = 4'b0000, R_CTRL = 4'b0001, R_INFO = 4'b0010, R_WDATA = 4'b0011,
    R_ADDR = 4'b0100, R_REPLY = 4'b0101, R_EXP = 4'b0110, R_PROG = 4'b0111,
    R_IEN = 4'b1000, R_PINS = 4'b1001
  } mdmd_reg_t;
endpackage : mdmd_pkg

/* File: mdmd_link_if.sv */
// Synchronised link events between the pin sampler and the frame engine
`timescale 1ns/10ps
interface mdmd_link_if;
  logic mdc_rise;
  logic mdio_bit;
  logic [4:0] port_pins;
  modport src (output mdc_rise, mdio_bit, port_pins);
  modport dst (input mdc_rise, mdio_bit, port_pins);
endinterface : mdmd_link_if

/* File: mdmd_sync.sv */
// Pin synchronisers and management clock edge finder
`timescale 1ns/10ps
module mdmd_sync (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Raw pins
  input wire logic mdc,
  input wire logic mdio,
  input wire logic [4:0] pins,
  // Synchronised side
  mdmd_link_if.src link
);
  logic mdc_m_q;
  logic mdc_q;
  logic mdc_prev_q;
  logic dio_m_q;
  logic dio_q;
  logic [4:0] pin_m_q;
  logic [4:0] pin_q;

  // Data and clock share one delay so the sample stays aligned
  always_ff @(posedge clk) begin
    if (rst) begin
      mdc_m_q <= 1'b0;
      mdc_q <= 1'b0;
      mdc_prev_q <= 1'b0;
      dio_m_q <= 1'b1;
      dio_q <= 1'b1;
      pin_m_q <= 5'h00;
      pin_q <= 5'h00;
    end else if (ce) begin
      mdc_m_q <= mdc;
      mdc_q <= mdc_m_q;
      mdc_prev_q <= mdc_q;
      dio_m_q <= mdio;
      dio_q <= dio_m_q;
      pin_m_q <= pins;
      pin_q <= pin_m_q;
    end
  end

  assign link.mdc_rise = mdc_q & ~mdc_prev_q;
  assign link.mdio_bit = dio_q;
  assign link.port_pins = pin_q;
endmodule : mdmd_sync

/* File: mdmd_top.sv */
// MDIO manageable device: frame engine, APB registers and progress flags
// Function
// [RULE1] Write frame data field lands in the captured write data register.
// [RULE2] Address frame field lands in the captured address register.
// [RULE3] Reply data register shifts out in read and increment frames.
// [RULE4] Software loads reply data before the following read frame needs it.
// [RULE5] Received device address is compared with software value, reset one.
// [RULE6] Per bit, select zero takes pin, one takes software port bit.
// [RULE7] End of port field sets port match or mismatch flag.
// [RULE8] End of device field sets device match or mismatch flag.
// [RULE9] Addressed read frame end sets read frame done.
// [RULE10] Addressed increment frame end sets increment frame done.
// [RULE11] Addressed address frame end sets address frame done.
// [RULE12] Addressed write frame end sets write frame done.
// [RULE13] Reading progress flags clears them; reset value zero.
// [RULE14] Each enable bit requests an interrupt for its flag.
// [RULE15] Pin levels register shows live port address pins.
// [RULE16] Opcodes: 00 address, 01 write, 11 read, 10 read increment.
// [RULE17] Host sends at least 32 preamble ones then two zero bits.
// [RULE18] Device drives line only in second turnaround bit and data.
// [RULE19] Three bit port option ignores unused port bits in compare.
// [RULE20] Interrupt output is OR of enabled active flags, drops on clear.
`timescale 1ns/10ps
module mdmd_top
  import mdmd_pkg::*;
(
  // Clock, reset, enable
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Management link pins
  input wire logic MDC,
  input wire logic MDIO_IN,
  output logic MDIO_OUT,
  output logic MDIO_OE,
  input wire logic [4:0] PORT_ADDRESS_PIN,
  // Interrupt
  output logic IRQ
);
  function automatic mdmd_reg_t reg_decode(input logic [31:0] a);
    if (a == ADDR_CONTROL) reg_decode = R_CTRL;
    else if (a == ADDR_FRAME_INFO) reg_decode = R_INFO;
    else if (a == ADDR_WRITE_DATA) reg_decode = R_WDATA;
    else if (a == ADDR_ADDRESS) reg_decode = R_ADDR;
    else if (a == ADDR_REPLY) reg_decode = R_REPLY;
    else if (a == ADDR_EXPECTED) reg_decode = R_EXP;
    else if (a == ADDR_PROGRESS) reg_decode = R_PROG;
    else if (a == ADDR_IRQ_EN) reg_decode = R_IEN;
    else if (a == ADDR_PIN_LEVELS) reg_decode = R_PINS;
    else reg_decode = R_NONE;
  endfunction : reg_decode

  mdmd_link_if link ();

  mdmd_sync u_sync (
    .clk (CORE_CLK),
    .rst (SYS_RST),
    .ce (CLK_EN),
    .mdc (MDC),
    .mdio (MDIO_IN),
    .pins (PORT_ADDRESS_PIN),
    .link (link)
  );

  mdmd_state_t st_q;
  logic [5:0] pre_cnt_q;
  logic [3:0] bit_q;
  logic [15:0] shift_q;
  logic [1:0] op_q;
  logic port_ok_q;
  logic dev_ok_q;
  logic [4:0] rx_port_q;
  logic [4:0] rx_dev_q;
  logic drive_q;
  logic out_q;
  logic [15:0] tx_q;
  logic [15:0] wdata_cap_q;
  logic [15:0] addr_cap_q;
  logic [15:0] reply_q;
  logic [14:0] cfg_q;
  logic [7:0] flags_q;
  logic [7:0] ien_q;
  logic narrow_q;
  logic [31:0] prdata_q;
  logic slverr_q;
  logic fresh_q;
  logic rise;
  logic din;
  logic [15:0] shin;
  logic [4:0] exp_port;
  logic [4:0] exp_dev;
  logic port_hit;
  logic dev_hit;
  logic port_end;
  logic dev_end;
  logic frame_end;
  logic addressed;
  logic [7:0] set_v;
  logic acc;
  logic wr_acc;
  logic sta_rd;
  logic [31:0] rd_word;
  mdmd_reg_t rd_sel;

  assign rise = link.mdc_rise & CLK_EN;
  assign din = link.mdio_bit;
  assign shin = {shift_q[14:0], din};

  // [RULE6] Port bit source mux
  genvar gi;
  generate
    for (gi = 0; gi < FIELD_W; gi++) begin : g_exp
      assign exp_port[gi] = cfg_q[PORTSEL_LSB + gi] ? cfg_q[PORTSW_LSB + gi] : link.port_pins[gi];
    end
  endgenerate
  assign exp_dev = cfg_q[DEVADD_LSB +: FIELD_W];

  // [RULE19] Narrow port compare
  assign port_hit = narrow_q ? (shin[NARROW_BITS-1:0] == exp_port[NARROW_BITS-1:0]) : (shin[4:0] == exp_port);
  // [RULE5] Device address compare
  assign dev_hit = shin[4:0] == exp_dev;

  assign port_end = rise && st_q == S_PRT && bit_q == FIELD_LAST;
  assign dev_end = rise && st_q == S_DEV && bit_q == FIELD_LAST;
  assign frame_end = rise && st_q == S_DATA && bit_q == DATA_LAST;
  assign addressed = port_ok_q && dev_ok_q;

  // Frame sequencer, advanced on each management clock rise
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      st_q <= S_PRE;
      pre_cnt_q <= 6'h00;
      bit_q <= 4'h0;
      op_q <= OP_SET_ADDRESS;
    end else if (rise) begin
      bit_q <= bit_q + 4'h1;
      case (st_q)
        // [RULE17] Preamble count then start bits
        S_PRE: begin
          bit_q <= 4'h0;
          if (din) begin
            if (pre_cnt_q != PREAMBLE_MIN) pre_cnt_q <= pre_cnt_q + 6'h01;
          end else if (pre_cnt_q == PREAMBLE_MIN) begin
            st_q <= S_ST;
            pre_cnt_q <= 6'h00;
          end else begin
            pre_cnt_q <= 6'h00;
          end
        end
        S_ST: begin
          bit_q <= 4'h0;
          if (din) begin
            st_q <= S_PRE;
            pre_cnt_q <= 6'h01;
          end else begin
            st_q <= S_OP;
          end
        end
        // [RULE16] Opcode capture
        S_OP: begin
          if (bit_q == OP_LAST) begin
            op_q <= shin[1:0];
            st_q <= S_PRT;
            bit_q <= 4'h0;
          end
        end
        S_PRT: begin
          if (bit_q == FIELD_LAST) begin
            st_q <= S_DEV;
            bit_q <= 4'h0;
          end
        end
        S_DEV: begin
          if (bit_q == FIELD_LAST) begin
            st_q <= S_TA;
            bit_q <= 4'h0;
          end
        end
        S_TA: begin
          if (bit_q == TA_LAST) begin
            st_q <= S_DATA;
            bit_q <= 4'h0;
          end
        end
        S_DATA: begin
          if (bit_q == DATA_LAST) begin
            st_q <= S_PRE;
            bit_q <= 4'h0;
          end
        end
        default: begin
          st_q <= S_PRE;
          bit_q <= 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) shift_q <= 16'h0000;
    else if (rise) shift_q <= shin;
  end

  // Field results, kept for the frame end and the info register
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      port_ok_q <= 1'b0;
      dev_ok_q <= 1'b0;
      rx_port_q <= 5'h00;
      rx_dev_q <= 5'h00;
    end else begin
      if (port_end) begin
        port_ok_q <= port_hit;
        rx_port_q <= shin[4:0];
      end
      if (dev_end) begin
        dev_ok_q <= dev_hit;
        rx_dev_q <= shin[4:0];
      end
    end
  end

  // Reply driver; unaddressed frames never turn the line round
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      drive_q <= 1'b0;
      out_q <= 1'b0;
      tx_q <= 16'h0000;
    end else if (rise) begin
      if (st_q == S_TA && bit_q == 4'h0 && op_q[1] && addressed) begin
        // [RULE18] Drive second turnaround bit low
        drive_q <= 1'b1;
        out_q <= 1'b0;
      end else if (st_q == S_TA && bit_q == TA_LAST && drive_q) begin
        // [RULE4] Reply taken at last possible moment
        out_q <= reply_q[15];
        tx_q <= {reply_q[14:0], 1'b0};
      end else if (st_q == S_DATA && drive_q) begin
        // [RULE3] Shift reply out msb first
        if (bit_q == DATA_LAST) begin
          drive_q <= 1'b0;
          out_q <= 1'b0;
        end else begin
          out_q <= tx_q[15];
          tx_q <= {tx_q[14:0], 1'b0};
        end
      end
    end
  end
  assign MDIO_OUT = out_q;
  assign MDIO_OE = drive_q;

  // Captures only for frames aimed at this port and device
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      wdata_cap_q <= REG_ZERO_RST;
      addr_cap_q <= REG_ZERO_RST;
    end else if (frame_end && addressed) begin
      // [RULE1] Write data capture
      if (op_q == OP_WRITE) wdata_cap_q <= shin;
      // [RULE2] Address capture
      if (op_q == OP_SET_ADDRESS) addr_cap_q <= shin;
    end
  end

  always_comb begin
    set_v = 8'h00;
    // [RULE7] Port result flags
    set_v[PORT_MISMATCH_FLAG] = port_end && !port_hit;
    set_v[PORT_MATCH_FLAG] = port_end && port_hit;
    // [RULE8] Device result flags
    set_v[DEVICE_MISMATCH_FLAG] = dev_end && !dev_hit;
    set_v[DEVICE_MATCH_FLAG] = dev_end && dev_hit;
    // [RULE9] Read frame done
    set_v[READ_FRAME_DONE] = frame_end && addressed && op_q == OP_READ;
    // [RULE10] Increment frame done
    set_v[INCREMENT_FRAME_DONE] = frame_end && addressed && op_q == OP_READ_INC;
    // [RULE11] Address frame done
    set_v[ADDRESS_FRAME_DONE] = frame_end && addressed && op_q == OP_SET_ADDRESS;
    // [RULE12] Write frame done
    set_v[WRITE_FRAME_DONE] = frame_end && addressed && op_q == OP_WRITE;
  end

  // APB: zero wait states while enabled; a setup missed while frozen costs one wait
  assign PREADY = CLK_EN && fresh_q;
  assign acc = PSEL && PENABLE && PREADY;
  assign wr_acc = acc && PWRITE;
  assign rd_sel = reg_decode(PADDR);
  assign sta_rd = acc && !PWRITE && rd_sel == R_PROG;

  // [RULE13] Clear only what the reader saw; a new set wins
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) flags_q <= REG_ZERO_RST[7:0];
    else if (CLK_EN) flags_q <= (flags_q & ~(sta_rd ? prdata_q[7:0] : 8'h00)) | set_v;
  end

  // Software written configuration
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      reply_q <= REG_ZERO_RST;
      cfg_q <= EXPECTED_CFG_RST[14:0];
      ien_q <= REG_ZERO_RST[7:0];
      narrow_q <= 1'b0;
    end else if (wr_acc) begin
      if (rd_sel == R_REPLY) reply_q <= PWDATA[15:0];
      else if (rd_sel == R_EXP) cfg_q <= PWDATA[14:0];
      else if (rd_sel == R_IEN) ien_q <= PWDATA[7:0];
      else if (rd_sel == R_CTRL) narrow_q <= PWDATA[PORT_WIDTH_SELECT_BIT];
    end
  end

  always_comb begin
    rd_word = 32'h0;
    case (rd_sel)
      R_CTRL: rd_word[PORT_WIDTH_SELECT_BIT] = narrow_q;
      R_INFO: rd_word[15:0] = {4'h0, rx_dev_q, rx_port_q, op_q};
      R_WDATA: rd_word[15:0] = wdata_cap_q;
      R_ADDR: rd_word[15:0] = addr_cap_q;
      R_REPLY: rd_word[15:0] = reply_q;
      R_EXP: rd_word[14:0] = cfg_q;
      R_PROG: rd_word[7:0] = flags_q;
      R_IEN: rd_word[7:0] = ien_q;
      // [RULE15] Live pin levels
      R_PINS: rd_word[4:0] = link.port_pins;
      default: rd_word = 32'h0;
    endcase
  end

  // Read data sampled each selected cycle while enabled, so the access shows it
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      prdata_q <= 32'h0;
      slverr_q <= 1'b0;
    end else if (CLK_EN && PSEL) begin
      prdata_q <= rd_word;
      slverr_q <= rd_sel == R_NONE;
    end
  end
  // Stale read data never completes a transfer
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) fresh_q <= 1'b0;
    else if (CLK_EN) fresh_q <= PSEL && !acc;
  end
  assign PRDATA = prdata_q;
  assign PSLVERR = slverr_q && PSEL && PENABLE && PREADY;

  // [RULE14] Per flag enable
  // [RULE20] Level interrupt
  assign IRQ = |(flags_q & ien_q);

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);

  property p_port_flag;
    port_end && port_hit |=> flags_q[PORT_MATCH_FLAG];
  endproperty
  a_port_flag: assert property (p_port_flag) else $error("port match flag not set"); // [RULE7]

  property p_dev_flag;
    dev_end && !dev_hit |=> flags_q[DEVICE_MISMATCH_FLAG];
  endproperty
  a_dev_flag: assert property (p_dev_flag) else $error("device mismatch flag not set"); // [RULE8]

  property p_read_done;
    frame_end && addressed && op_q == OP_READ |=> flags_q[READ_FRAME_DONE] && !MDIO_OE;
  endproperty
  a_read_done: assert property (p_read_done) else $error("read frame end wrong"); // [RULE9]

  property p_drive_window;
    MDIO_OE |-> op_q[1] && addressed && (st_q == S_TA || st_q == S_DATA);
  endproperty
  a_drive_window: assert property (p_drive_window) else $error("line driven outside reply"); // [RULE18]

  property p_first_bit;
    rise && st_q == S_TA && bit_q == TA_LAST && drive_q |=> MDIO_OUT == $past(reply_q[15]) && MDIO_OE;
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("first reply bit wrong"); // [RULE3]

  property p_wdata;
    frame_end && addressed && op_q == OP_WRITE |=> wdata_cap_q == $past(shin) && flags_q[WRITE_FRAME_DONE];
  endproperty
  a_wdata: assert property (p_wdata) else $error("write data not captured"); // [RULE1]

  property p_clear;
    sta_rd && set_v == 8'h00 && flags_q == prdata_q[7:0] |=> flags_q == 8'h00 && !IRQ;
  endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared by read"); // [RULE13]

  property p_irq_rise;
    $rose(IRQ) |-> $past(|(set_v & ien_q)) || $past(wr_acc);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose without cause"); // [RULE20]

  property p_pins;
    PSEL && !PENABLE && CLK_EN && reg_decode(PADDR) == R_PINS |=> PRDATA[4:0] == $past(link.port_pins);
  endproperty
  a_pins: assert property (p_pins) else $error("pin levels read wrong"); // [RULE15]

  c_read_frame: cover property (frame_end && addressed && op_q == OP_READ);
  c_write_frame: cover property (frame_end && addressed && op_q == OP_WRITE);
  c_irq: cover property ($rose(IRQ));
  c_status_read: cover property (sta_rd && flags_q != 8'h00);
endmodule : mdmd_top

/* File: mdmd_host_model.sv */
// Behavioural management host that drives frames on the link pins
`timescale 1ns/10ps
module mdmd_host_model (
  // Core clock for the released-line pattern
  input wire logic CORE_CLK,
  // Device side of the line
  input wire logic MDIO_OUT,
  input wire logic MDIO_OE,
  // Host side of the line
  output logic MDC,
  output logic MDIO_IN
);
  logic host_en = 1'b0;
  logic host_val = 1'b1;
  logic last_q = 1'b0;
  int clashes = 0;

  // Released line toggles so a stale value never passes
  assign MDIO_IN = MDIO_OE ? MDIO_OUT : (host_en ? host_val : ~last_q);

  always @(posedge CORE_CLK) begin
    last_q <= MDIO_IN;
  end

  initial begin
    MDC = 1'b0;
  end

  // One bit: set line while clock low, sample at rise
  task automatic bit_out(input logic en, input logic v, input logic dev_drv, output logic smp);
    host_en = en;
    host_val = v;
    #80;
    smp = MDIO_IN;
    if (MDIO_OE !== dev_drv) clashes++;
    MDC = 1'b1;
    #80;
    MDC = 1'b0;
  endtask : bit_out

  task automatic frame(input logic [1:0] op, input logic [4:0] port, input logic [4:0] dev,
                       input logic [15:0] wd, input logic hit, output logic [15:0] rd);
    logic [45:0] hdr;
    logic s;
    logic rdop;
    int i;
    // Step off the core clock edge so pins never race the sampler
    #1;
    rdop = op[1];
    hdr = {32'hffffffff, 2'b00, op, port, dev};
    for (i = 45; i >= 0; i--) bit_out(1'b1, hdr[i], 1'b0, s);
    bit_out(!rdop, 1'b1, 1'b0, s);
    bit_out(!rdop, 1'b0, rdop & hit, s);
    for (i = 15; i >= 0; i--) begin
      bit_out(!rdop, wd[i], rdop & hit, s);
      rd[i] = s;
    end
    // Clock stands still between frames
    host_en = 1'b0;
  endtask : frame
endmodule : mdmd_host_model

/* File: tb_mdio_manageable_device_regs.sv */
// Self-checking bench: APB register access and host frames
`timescale 1ns/10ps
module tb_mdio_manageable_device_regs
  import mdmd_pkg::*;
;
  logic CORE_CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic MDC;
  logic MDIO_IN;
  logic MDIO_OUT;
  logic MDIO_OE;
  logic [4:0] pins = 5'h15;
  logic IRQ;
  logic [7:0] ien = 8'h0;
  int mismatches = 0;
  int samples_checked = 0;

  mdmd_top u_dut (
    .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CLK_EN(clk_en),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .MDC(MDC), .MDIO_IN(MDIO_IN), .MDIO_OUT(MDIO_OUT), .MDIO_OE(MDIO_OE),
    .PORT_ADDRESS_PIN(pins), .IRQ(IRQ)
  );

  mdmd_host_model u_host (
    .CORE_CLK(CORE_CLK), .MDIO_OUT(MDIO_OUT), .MDIO_OE(MDIO_OE), .MDC(MDC), .MDIO_IN(MDIO_IN)
  );

  initial begin
    forever #2.5 CORE_CLK = ~CORE_CLK;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One APB transfer; an edge always passes before the next setup
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge CORE_CLK);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge CORE_CLK);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    rd = PRDATA;
    err = PSLVERR;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic e;
    apb(1'b0, a, 32'h0, v, e);
    check(v, exp);
  endtask : rd_chk

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] v;
    logic e;
    apb(1'b1, a, d, v, e);
  endtask : wr

  task automatic run(input logic [1:0] op, input logic [4:0] port, input logic [4:0] dev,
                     input logic [15:0] d, input logic [7:0] flags);
    logic [15:0] rd;
    logic hit;
    hit = flags[PORT_MATCH_FLAG] & flags[DEVICE_MATCH_FLAG];
    if (op[1]) wr(ADDR_REPLY, {16'h0, d});
    u_host.frame(op, port, dev, d, hit, rd);
    repeat (10) @(posedge CORE_CLK);
    if (op[1] && hit) check({16'h0, rd}, {16'h0, d});
    check({31'h0, MDIO_OE}, 32'h0);
    check({31'h0, IRQ}, {31'h0, |(flags & ien)});
    rd_chk(ADDR_FRAME_INFO, {20'h0, dev, port, op});
    if (hit && op == OP_WRITE) rd_chk(ADDR_WRITE_DATA, {16'h0, d});
    if (hit && op == OP_SET_ADDRESS) rd_chk(ADDR_ADDRESS, {16'h0, d});
    rd_chk(ADDR_PROGRESS, {24'h0, flags});
    rd_chk(ADDR_PROGRESS, 32'h0);
    check({31'h0, IRQ}, 32'h0);
  endtask : run

  initial begin
    logic [31:0] v;
    logic e;
    repeat (10) @(posedge CORE_CLK);
    SYS_RST <= 1'b0;
    rd_chk(ADDR_EXPECTED, 32'h0400);
    rd_chk(ADDR_PROGRESS, 32'h0);
    rd_chk(ADDR_IRQ_EN, 32'h0);
    rd_chk(ADDR_REPLY, 32'h0);
    rd_chk(ADDR_PIN_LEVELS, 32'h15);
    pins <= 5'h0b;
    // Pins pass two sampler stages first
    repeat (3) @(posedge CORE_CLK);
    rd_chk(ADDR_PIN_LEVELS, 32'h0b);
    // Unmapped place answers with an error
    apb(1'b0, 32'h40005c24, 32'h0, v, e);
    check({31'h0, e}, 32'h1);
    // Read-only capture ignores writes
    wr(ADDR_WRITE_DATA, 32'hffff);
    rd_chk(ADDR_WRITE_DATA, 32'h0);
    wr(ADDR_IRQ_EN, 32'hff);
    ien = 8'hff;
    rd_chk(ADDR_IRQ_EN, 32'hff);
    // Pin-sourced port address, every opcode
    run(OP_SET_ADDRESS, 5'h0b, 5'h01, 16'h1234, 8'h52);
    run(OP_WRITE, 5'h0b, 5'h01, 16'ha5c3, 8'h51);
    run(OP_READ, 5'h0b, 5'h01, 16'hbeef, 8'h58);
    run(OP_READ_INC, 5'h0b, 5'h01, 16'h0f0f, 8'h54);
    run(OP_WRITE, 5'h0a, 5'h01, 16'h5555, 8'h90);
    run(OP_READ, 5'h0b, 5'h02, 16'h7777, 8'h60);
    rd_chk(ADDR_WRITE_DATA, 32'ha5c3);
    // Software port bits and device address two
    wr(ADDR_EXPECTED, 32'h0bea);
    rd_chk(ADDR_EXPECTED, 32'h0bea);
    // Setup made while frozen still returns fresh data
    clk_en <= 1'b0;
    fork
      rd_chk(ADDR_EXPECTED, 32'h0bea);
      begin
        repeat (6) @(posedge CORE_CLK);
        clk_en <= 1'b1;
      end
    join
    run(OP_SET_ADDRESS, 5'h0a, 5'h02, 16'h8001, 8'h52);
    run(OP_WRITE, 5'h0b, 5'h02, 16'h1111, 8'h90);
    // Narrow compare ignores the top two port bits
    wr(ADDR_CONTROL, 32'h2);
    run(OP_WRITE, 5'h12, 5'h02, 16'h2222, 8'h51);
    // Masked flags keep the interrupt low; the enabled write frame done flag raises it
    wr(ADDR_IRQ_EN, 32'h01);
    ien = 8'h01;
    run(OP_SET_ADDRESS, 5'h0a, 5'h02, 16'h3333, 8'h52);
    run(OP_WRITE, 5'h0a, 5'h02, 16'h4444, 8'h51);
    check(u_host.clashes, 32'h0);
    results();
  end

  // Frames take about 2050 cycles each; generous margin
  initial begin
    repeat (90000) @(posedge CORE_CLK);
    mismatches++;
    results();
  end
endmodule : tb_mdio_manageable_device_regs
